/* hw/rup_status_reload.sv */
// reconfiguration cause recorder, status capture path and control reload sequencer
//
// What this block does
// R01 - record which of five causes triggered each reconfiguration out of an application image
// R02 - factory current-state word: master state, six zero bits, 24-bit boot address
// R03 - application word one: master state, watchdog enable, full 29-bit time-out value
// R04 - application word two: master state, six zero bits, current boot address
// R05 - keep two 31-bit previous records, newest and the one before, same layout
// R06 - record bits 30..26 one-hot: reset, crc, status error, watchdog, core request
// R07 - simultaneous causes flag only the highest bit position
// R08 - record bits 25:24 master state at trigger, 23:0 boot address used
// R09 - capturing an empty previous record shifts out an invalid marker
// R10 - update writes by user only in factory; control written only by sequencer
// R11 - user loads update register in factory before requesting reconfiguration
// R12 - core request rising copies update into control, then loads new page
// R13 - user holds core reconfiguration request high at least 250 ns
// R14 - any trigger sets control to load factory or application image
// R15 - errors and resets clear control to zero; core trigger copies update register
// R16 - status records written after detection, before the image load starts
// R17 - capture loads the selected status word into the shift register
// R18 - control, status, shift and update all run on the one block clock
// R19 - control register powers up all zero so the factory image loads first
// R20 - master state code 0 means factory, 1 means application
`timescale 1ns/1ns
`default_nettype none

module rup_status_reload (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // external pins, active low, asynchronous
   input wire logic config_reset_n_in,
   input wire logic external_status_error_n_in,
   // configuration engine, same clock
   input wire logic crc_error_in,
   input wire logic watchdog_timeout_flag_in,
   input wire logic load_done_in,
   // user logic, same clock
   input wire logic core_reconfig_request_in,
   input wire logic capture_in,
   input wire logic [1:0] capture_select_in,
   input wire logic read_control_in,
   input wire logic shift_in,
   input wire logic serial_in,
   input wire logic update_in,
   // user logic results
   output logic serial_out,
   output logic [1:0] master_state_out,
   // configuration engine requests
   output logic load_start_out,
   output rup_pkg::rup_load_type load_out
);

   // ==================================================================
   // declarations
   rup_pkg::rup_state_type state;
   rup_pkg::rup_ctrl_type control;
   rup_pkg::rup_ctrl_type update;
   rup_pkg::rup_prev_type previous_one;
   rup_pkg::rup_prev_type previous_two;
   rup_pkg::rup_shift_type shift_reg;
   logic [1:0] pin_level;
   logic [1:0] pin_level_d;
   logic crc_d;
   logic watchdog_d;
   logic core_d;
   logic [4:0] raw_source;
   logic [4:0] next_source;
   logic [4:0] pending_source;
   logic [1:0] master_state;
   logic [1:0] state_at_trigger;
   logic dest_app;
   logic previous_one_valid;
   logic previous_two_valid;
   logic idle;
   logic trigger;
   logic [31:0] current_word_a;
   logic [31:0] current_word_b;
   logic [31:0] capture_word;

   // ==================================================================
   // pin synchronisers
   rup_pin_sync #(
      .WIDTH(2),
      .IDLE(rup_pkg::PIN_IDLE)
   ) u_pin_sync (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .pin_in({config_reset_n_in, external_status_error_n_in}),
      .level_out(pin_level)
   );

   // ==================================================================
   // edge detection of the trigger sources
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         pin_level_d <= rup_pkg::PIN_IDLE;
         crc_d <= 1'b0;
         watchdog_d <= 1'b0;
         core_d <= 1'b0;
      end else begin
         pin_level_d <= pin_level;
         crc_d <= crc_error_in;
         watchdog_d <= watchdog_timeout_flag_in;
         core_d <= core_reconfig_request_in;
      end
   end

   // each cause fires once per assertion, not per cycle held
   always_comb begin
      raw_source = rup_pkg::SRC_NONE;
      raw_source[rup_pkg::SRC_CONFIG_RESET] = pin_level_d[1] & ~pin_level[1]; // [R01]
      raw_source[rup_pkg::SRC_CRC_ERROR] = crc_error_in & ~crc_d; // [R01]
      raw_source[rup_pkg::SRC_STATUS_ERROR] = pin_level_d[0] & ~pin_level[0]; // [R01]
      // watchdog is never running in a factory image
      raw_source[rup_pkg::SRC_WATCHDOG] = watchdog_timeout_flag_in & ~watchdog_d
         & (master_state == rup_pkg::MS_APP); // [R01]
      // a single edge suffices; the 250 ns hold is the user's side of the deal
      raw_source[rup_pkg::SRC_CORE] = core_reconfig_request_in & ~core_d; // [R12] [R13]
      next_source = rup_pkg::pick_source(raw_source); // [R07]
   end

   // triggers are only taken while an image is running, not mid-sequence
   assign idle = (state == rup_pkg::RUP_ST_FACTORY) || (state == rup_pkg::RUP_ST_APP);
   assign trigger = idle && (raw_source != rup_pkg::SRC_NONE);

   // ==================================================================
   // reload sequencer
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state <= rup_pkg::RUP_ST_FACTORY;
      end else begin
         unique case (state)
            rup_pkg::RUP_ST_FACTORY, rup_pkg::RUP_ST_APP: begin
               if (trigger) begin
                  state <= rup_pkg::RUP_ST_RECORD;
               end
            end
            // status first, control second, load third
            rup_pkg::RUP_ST_RECORD: begin
               state <= rup_pkg::RUP_ST_CONTROL; // [R16]
            end
            rup_pkg::RUP_ST_CONTROL: begin
               state <= rup_pkg::RUP_ST_LOAD;
            end
            rup_pkg::RUP_ST_LOAD: begin
               state <= rup_pkg::RUP_ST_WAIT;
            end
            rup_pkg::RUP_ST_WAIT: begin
               if (load_done_in) begin
                  state <= dest_app ? rup_pkg::RUP_ST_APP : rup_pkg::RUP_ST_FACTORY; // [R14]
               end
            end
         endcase
      end
   end

   // latch the winning cause and the state it interrupted
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         pending_source <= rup_pkg::SRC_NONE;
         state_at_trigger <= rup_pkg::MS_FACTORY;
      end else if (trigger) begin
         pending_source <= next_source; // [R07]
         state_at_trigger <= master_state; // [R08]
      end
   end

   // master state follows the image that finished loading
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         master_state <= rup_pkg::MS_FACTORY; // [R20]
      end else if (state == rup_pkg::RUP_ST_WAIT && load_done_in) begin
         master_state <= dest_app ? rup_pkg::MS_APP : rup_pkg::MS_FACTORY; // [R20]
      end
   end

   // ==================================================================
   // previous-state records, written before the load begins
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         previous_one <= rup_pkg::PREV_RESET;
         previous_two <= rup_pkg::PREV_RESET;
         previous_one_valid <= 1'b0;
         previous_two_valid <= 1'b0;
      end else if (state == rup_pkg::RUP_ST_RECORD && state_at_trigger == rup_pkg::MS_APP) begin
         // only leaving an application image is worth a record
         previous_two <= previous_one; // [R05]
         previous_two_valid <= previous_one_valid; // [R05]
         previous_one.source <= pending_source; // [R06] [R16]
         previous_one.master_state <= state_at_trigger; // [R08]
         previous_one.boot_address <= rup_pkg::boot_address(control); // [R08]
         previous_one_valid <= 1'b1;
      end
   end

   // ==================================================================
   // control register: only the sequencer writes it
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         control <= rup_pkg::CTRL_RESET; // [R19]
         dest_app <= 1'b0;
      end else if (state == rup_pkg::RUP_ST_CONTROL) begin
         if (pending_source == rup_pkg::SRC_ONLY_CORE) begin
            control <= update; // [R12] [R15]
            dest_app <= 1'b1; // [R14]
         end else begin
            control <= rup_pkg::CTRL_RESET; // [R15]
            dest_app <= 1'b0; // [R14]
         end
      end
   end

   // update register: user writes are ignored outside a factory image
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         update <= rup_pkg::CTRL_RESET;
      end else if (update_in && state == rup_pkg::RUP_ST_FACTORY) begin
         update <= rup_pkg::rup_ctrl_type'(shift_reg[rup_pkg::CTRL_W-1:0]); // [R10] [R11]
      end
   end

   // ==================================================================
   // current-state words and capture selection
   always_comb begin
      current_word_a = {master_state, rup_pkg::STAT_PAD, rup_pkg::boot_address(control)}; // [R02]
      current_word_b = current_word_a;
      if (master_state == rup_pkg::MS_APP) begin
         current_word_a = {master_state, control.wd_enable, rup_pkg::wd_value(control)}; // [R03]
         current_word_b = {master_state, rup_pkg::STAT_PAD,
            rup_pkg::boot_address(control)}; // [R04]
      end
      unique case (capture_select_in)
         rup_pkg::CAP_CURRENT_A: capture_word = current_word_a;
         rup_pkg::CAP_CURRENT_B: capture_word = current_word_b;
         rup_pkg::CAP_PREVIOUS_ONE: begin
            capture_word = previous_one_valid ? {1'b0, previous_one}
               : rup_pkg::CAPTURE_INVALID; // [R09]
         end
         rup_pkg::CAP_PREVIOUS_TWO: begin
            capture_word = previous_two_valid ? {1'b0, previous_two}
               : rup_pkg::CAPTURE_INVALID; // [R09]
         end
      endcase
   end

   // ==================================================================
   // user shift register: capture wins over read, read over shift
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         shift_reg <= '0;
      end else if (capture_in) begin
         shift_reg <= rup_pkg::rup_shift_type'(capture_word); // [R17]
      end else if (read_control_in) begin
         // factory reads the pending update, application the live control
         if (master_state == rup_pkg::MS_FACTORY) begin
            shift_reg <= rup_pkg::rup_shift_type'(update);
         end else begin
            shift_reg <= rup_pkg::rup_shift_type'(control);
         end
      end else if (shift_in) begin
         shift_reg <= {serial_in, shift_reg[rup_pkg::SHIFT_W-1:1]};
      end
   end

   // serial output lags the register by one cycle to stay a flop output
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= shift_reg[0];
      end
   end

   // ==================================================================
   // load request towards the configuration engine
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         load_start_out <= 1'b0;
         load_out <= rup_pkg::LOAD_RESET;
      end else begin
         load_start_out <= (state == rup_pkg::RUP_ST_LOAD); // [R12] [R14]
         if (state == rup_pkg::RUP_ST_LOAD) begin
            load_out.boot_address <= rup_pkg::boot_address(control);
            load_out.early_done_check_option <= control.early_done_check_option;
            load_out.internal_osc_option <= control.internal_osc_option;
            load_out.wd_enable <= control.wd_enable;
            load_out.wd_value <= rup_pkg::wd_value(control);
         end
      end
   end

   // master state mirror for the user side
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         master_state_out <= rup_pkg::MS_FACTORY;
      end else begin
         master_state_out <= master_state; // [R18]
      end
   end

endmodule // rup_status_reload

`default_nettype wire

/* inc/rup_pkg.sv */
// shared constants, field layouts and types of the remote upgrade status and reload block
package rup_pkg;

   // ==================================================================
   // widths
   localparam int CTRL_W = 37;
   localparam int SHIFT_W = 40;
   localparam int STAT_W = 32;
   localparam int PREV_W = 31;
   localparam int BOOT_W = 24;
   localparam int BOOT_HI_W = 22;
   localparam int WD_TIMER_W = 12;
   localparam int WD_VALUE_W = 29;
   localparam int SRC_W = 5;

   // ==================================================================
   // master state encoding shown in the status words
   localparam logic [1:0] MS_FACTORY = 2'h0;
   localparam logic [1:0] MS_APP = 2'h1;

   // ==================================================================
   // one-hot source field positions inside the 5-bit source vector
   localparam int SRC_CONFIG_RESET = 4;
   localparam int SRC_CRC_ERROR = 3;
   localparam int SRC_STATUS_ERROR = 2;
   localparam int SRC_WATCHDOG = 1;
   localparam int SRC_CORE = 0;
   localparam logic [4:0] SRC_NONE = 5'h00;
   localparam logic [4:0] SRC_ONLY_CORE = 5'h01;

   // ==================================================================
   // fixed low bits appended to the stored fields, and the six zero pad bits of the status words
   localparam logic [16:0] WD_LOW_APPEND = 17'h00008;
   localparam logic [1:0] BOOT_LOW_APPEND = 2'h0;
   localparam logic [5:0] STAT_PAD = 6'h00;

   // ==================================================================
   // capture selection codes
   localparam logic [1:0] CAP_CURRENT_A = 2'h0;
   localparam logic [1:0] CAP_CURRENT_B = 2'h1;
   localparam logic [1:0] CAP_PREVIOUS_ONE = 2'h2;
   localparam logic [1:0] CAP_PREVIOUS_TWO = 2'h3;

   // all ones cannot be a real record: the source field is one-hot
   localparam logic [31:0] CAPTURE_INVALID = 32'hffff_ffff;

   // ==================================================================
   // reset values of the synchronised pins (active low, idle high)
   localparam logic [1:0] PIN_IDLE = 2'h3;

   // ==================================================================
   // types
   typedef logic [SHIFT_W-1:0] rup_shift_type;

   typedef struct packed {
      logic [WD_TIMER_W-1:0] wd_timer;
      logic [BOOT_HI_W-1:0] boot_addr_hi;
      logic wd_enable;
      logic internal_osc_option;
      logic early_done_check_option;
   } rup_ctrl_type;

   typedef struct packed {
      logic [SRC_W-1:0] source;
      logic [1:0] master_state;
      logic [BOOT_W-1:0] boot_address;
   } rup_prev_type;

   typedef struct packed {
      logic [BOOT_W-1:0] boot_address;
      logic early_done_check_option;
      logic internal_osc_option;
      logic wd_enable;
      logic [WD_VALUE_W-1:0] wd_value;
   } rup_load_type;

   typedef enum {
      RUP_ST_FACTORY,
      RUP_ST_APP,
      RUP_ST_RECORD,
      RUP_ST_CONTROL,
      RUP_ST_LOAD,
      RUP_ST_WAIT
   } rup_state_type;

   localparam rup_ctrl_type CTRL_RESET = '0;
   localparam rup_prev_type PREV_RESET = '0;
   localparam rup_load_type LOAD_RESET = '0;

   // ==================================================================
   // helpers
   function automatic logic [BOOT_W-1:0] boot_address(input rup_ctrl_type c);
      return {c.boot_addr_hi, BOOT_LOW_APPEND};
   endfunction

   function automatic logic [WD_VALUE_W-1:0] wd_value(input rup_ctrl_type c);
      return {c.wd_timer, WD_LOW_APPEND};
   endfunction

   // keep only the highest set source bit
   function automatic logic [SRC_W-1:0] pick_source(input logic [SRC_W-1:0] v);
      logic [SRC_W-1:0] r;
      r = SRC_NONE;
      for (int i = 0; i < SRC_W; i++) begin
         if (v[i]) begin
            r = SRC_NONE;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

endpackage

/* hw/rup_pin_sync.sv */
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module rup_pin_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] IDLE = '0
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // asynchronous levels
   input wire logic [WIDTH-1:0] pin_in,
   // filtered levels
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] stage_two;
   logic [WIDTH-1:0] stage_three;

   // ==================================================================
   // stage one feeds only stage two
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         stage_one <= IDLE;
         stage_two <= IDLE;
         stage_three <= IDLE;
      end else begin
         stage_one <= pin_in;
         stage_two <= stage_one;
         stage_three <= stage_two;
      end
   end

   // per bit, a change counts once two and three agree
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         level_out <= IDLE;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage_two[i] == stage_three[i]) begin
               level_out[i] <= stage_three[i];
            end
         end
      end
   end

endmodule // rup_pin_sync

`default_nettype wire

/* tb/rup_status_reload_props.sv */
// concurrent checks on the ports of the status and reload block
`timescale 1ns/1ns
`default_nettype none

module rup_status_reload_props (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // trigger inputs and load done
   input wire logic config_reset_n_in,
   input wire logic external_status_error_n_in,
   input wire logic crc_error_in,
   input wire logic watchdog_timeout_flag_in,
   input wire logic core_reconfig_request_in,
   input wire logic load_done_in,
   // capture inputs
   input wire logic capture_in,
   input wire logic [1:0] capture_select_in,
   // outputs
   input wire logic serial_out,
   input wire logic [1:0] master_state_out,
   input wire logic load_start_out,
   input wire rup_pkg::rup_load_type load_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   // cleared control still has watchdog low bits
   localparam rup_pkg::rup_load_type ZERO_LOAD = 56'h8;

   // ==========
   // no application seen since reset
   logic no_app;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         no_app <= 1'b1;
      end else if (master_state_out == rup_pkg::MS_APP) begin
         no_app <= 1'b0;
      end
   end

   // ==========
   // sequences
   sequence s_zero_load;
      load_start_out && load_out == ZERO_LOAD;
   endsequence
   sequence s_app_error;
      master_state_out == rup_pkg::MS_APP && $rose(crc_error_in);
   endsequence

   // ==========
   // assertions
   a_core_starts_load: assert property ($rose(core_reconfig_request_in) |-> ##[3:5] load_start_out)
      else $error("core request: no load start");
   a_crc_clears_ctrl: assert property (s_app_error |-> ##[3:5] s_zero_load)
      else $error("crc: no cleared load");
   a_pin_reset_load: assert property ($fell(config_reset_n_in) |-> ##[4:12] s_zero_load)
      else $error("reset pin: no cleared load");
   a_status_pin_load: assert property ($fell(external_status_error_n_in) |-> ##[4:12] s_zero_load)
      else $error("status pin: no cleared load");
   a_factory_wd_ignored: assert property (master_state_out == rup_pkg::MS_FACTORY &&
      $rose(watchdog_timeout_flag_in) |-> ##1 !load_start_out [*6])
      else $error("watchdog acted in factory");
   a_start_one_cycle: assert property (load_start_out |=> !load_start_out)
      else $error("load start too long");
   a_load_word_holds: assert property (!load_start_out |-> $stable(load_out))
      else $error("load word changed");
   a_empty_record: assert property (capture_in && no_app &&
      capture_select_in == rup_pkg::CAP_PREVIOUS_TWO |-> ##2 serial_out)
      else $error("no invalid marker");
   a_word_b_bit0: assert property (capture_in &&
      capture_select_in == rup_pkg::CAP_CURRENT_B |-> ##2 !serial_out)
      else $error("boot bit0 not zero");
   a_state_after_done: assert property ($changed(master_state_out) |->
      $past(load_done_in) || $past(load_done_in, 2) || $past(load_done_in, 3))
      else $error("state change without done");
endmodule // rup_status_reload_props

bind rup_status_reload rup_status_reload_props rup_status_reload_props_inst (
   .ref_clk_in, .srst_in, .config_reset_n_in, .external_status_error_n_in, .crc_error_in,
   .watchdog_timeout_flag_in, .load_done_in, .core_reconfig_request_in, .capture_in,
   .capture_select_in, .serial_out, .master_state_out, .load_start_out, .load_out
);
`default_nettype wire

/* tb/rup_user_model.sv */
// user-side stand-in: strobes the reload request and answers each image load
`timescale 1ns/1ns
`default_nettype none

module rup_user_model (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // bench commands and the block's load start
   input wire logic go_in,
   input wire logic [3:0] delay_in,
   input wire logic load_start_in,
   // towards the block
   output logic core_reconfig_request_out,
   output logic load_done_out
);
   int hold_cnt;
   int done_cnt;

   // request held 32 cycles, just over 250 ns at 8 ns, so page switch is safe
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         hold_cnt <= 0;
      end else if (go_in) begin
         hold_cnt <= 32;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   assign core_reconfig_request_out = (hold_cnt > 0);

   // done after a chosen delay, so prompt and slow engines both occur
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         done_cnt <= 0;
      end else if (load_start_in) begin
         done_cnt <= int'(delay_in) + 1;
      end else if (done_cnt > 0) begin
         done_cnt <= done_cnt - 1;
      end
   end
   assign load_done_out = (done_cnt == 1);
endmodule // rup_user_model
`default_nettype wire

/* tb/rup_status_reload_test.sv */
// self-checking bench: serial access tasks, reload sequences and status checks
`timescale 1ns/1ns
`default_nettype none

module rup_status_reload_test;
   // second control word sits at the field limits
   localparam rup_pkg::rup_ctrl_type C1 = {12'h5a3, 22'h15c3d7, 3'h6};
   localparam rup_pkg::rup_ctrl_type C2 = {12'hfff, 22'h3fffff, 3'h1};
   localparam rup_pkg::rup_load_type ZERO_LOAD = 56'h8;
   localparam logic [63:0] EMPTY = 64'hffff_ffff;
   logic ref_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic cfg_n = 1'b1;
   logic stat_n = 1'b1;
   logic crc = 1'b0;
   logic wdt = 1'b0;
   logic cap = 1'b0;
   logic rdc = 1'b0;
   logic shf = 1'b0;
   logic sdi = 1'b0;
   logic upd = 1'b0;
   logic [1:0] sel = 2'h0;
   logic go = 1'b0;
   logic [3:0] delay = 4'h0;
   logic req;
   logic done;
   logic sdo;
   logic [1:0] ms;
   logic start;
   rup_pkg::rup_load_type load;
   int n_errors = 0;
   int samples_checked = 0;

   // clock, 8 ns period
   always #4 ref_clk_in = ~ref_clk_in;

   rup_status_reload rup_status_reload_inst (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .config_reset_n_in(cfg_n),
      .external_status_error_n_in(stat_n), .crc_error_in(crc),
      .watchdog_timeout_flag_in(wdt), .load_done_in(done), .core_reconfig_request_in(req),
      .capture_in(cap), .capture_select_in(sel), .read_control_in(rdc), .shift_in(shf),
      .serial_in(sdi), .update_in(upd), .serial_out(sdo), .master_state_out(ms),
      .load_start_out(start), .load_out(load));
   rup_user_model rup_user_model_inst (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .go_in(go), .delay_in(delay),
      .load_start_in(start), .core_reconfig_request_out(req), .load_done_out(done));

   // ==========
   // helpers
   task automatic step();
      @(posedge ref_clk_in);
      #1;
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [23:0] boot(input rup_pkg::rup_ctrl_type c);
      return {c.boot_addr_hi, 2'h0};
   endfunction

   function automatic rup_pkg::rup_load_type mk_load(input rup_pkg::rup_ctrl_type c);
      return {boot(c), c.early_done_check_option, c.internal_osc_option, c.wd_enable,
         c.wd_timer, 17'h00008};
   endfunction

   task automatic do_reset();
      srst_in = 1'b1;
      repeat (10) step();
      srst_in = 1'b0;
      repeat (6) step();
   endtask

   // capture (rd=0) or read control (rd=1), shift 40 bits out lsb first, compare
   task automatic fetch(input logic rd, input logic [1:0] s, input string what,
         input logic [63:0] exp);
      logic [39:0] w;
      cap = !rd;
      rdc = rd;
      sel = s;
      step();
      cap = 1'b0;
      rdc = 1'b0;
      shf = 1'b1;
      step();
      for (int i = 0; i < 40; i++) begin
         w[i] = sdo;
         step();
      end
      shf = 1'b0;
      step();
      chk(what, exp, 64'(w));
   endtask

   // shift a control word in lsb first, then commit it
   task automatic put_update(input rup_pkg::rup_ctrl_type c);
      logic [39:0] w;
      w = {3'h0, c};
      shf = 1'b1;
      for (int i = 0; i < 40; i++) begin
         sdi = w[i];
         step();
      end
      shf = 1'b0;
      upd = 1'b1;
      step();
      upd = 1'b0;
   endtask

   // bounded waits for load start, then state
   task automatic wait_load(input rup_pkg::rup_load_type exp, input logic [1:0] ms_exp);
      int n;
      n = 0;
      while (start !== 1'b1 && n < 60) begin
         step();
         n++;
      end
      if (n == 60) begin
         chk("load_start", 64'h1, 64'(start));
         end_of_test();
      end
      chk("load_out", 64'(exp), 64'(load));
      n = 0;
      while (ms !== ms_exp && n < 60) begin
         step();
         n++;
      end
      chk("master_state", 64'(ms_exp), 64'(ms));
      if (n == 60) begin
         end_of_test();
      end
   endtask

   // ==========
   // test sequence
   initial begin
      do_reset();
      chk("master_state", 64'(rup_pkg::MS_FACTORY), 64'(ms));
      chk("load_out", 64'h0, 64'(load));
      fetch(1'b0, rup_pkg::CAP_PREVIOUS_TWO, "empty record", EMPTY);
      fetch(1'b0, rup_pkg::CAP_CURRENT_A, "factory word", 64'h0);
      wdt = 1'b1;
      repeat (8) step();
      chk("load_start", 64'h0, 64'(start));
      wdt = 1'b0;
      $display("test reset state done");
      // factory to application with a prompt engine
      put_update(C1);
      fetch(1'b1, 2'h0, "update read", 64'(C1));
      go = 1'b1;
      step();
      go = 1'b0;
      wait_load(mk_load(C1), rup_pkg::MS_APP);
      fetch(1'b0, rup_pkg::CAP_CURRENT_A, "app word a",
         64'({rup_pkg::MS_APP, C1.wd_enable, C1.wd_timer, 17'h8}));
      fetch(1'b0, rup_pkg::CAP_CURRENT_B, "app word b",
         64'({rup_pkg::MS_APP, 6'h0, boot(C1)}));
      put_update(C2);
      fetch(1'b1, 2'h0, "control kept", 64'(C1));
      $display("test application entry done");
      // crc and watchdog together, slow engine: crc outranks watchdog
      delay = 4'h9;
      crc = 1'b1;
      wdt = 1'b1;
      wait_load(ZERO_LOAD, rup_pkg::MS_FACTORY);
      crc = 1'b0;
      wdt = 1'b0;
      fetch(1'b0, rup_pkg::CAP_PREVIOUS_ONE, "record one",
         64'({1'b0, 5'h08, rup_pkg::MS_APP, boot(C1)}));
      fetch(1'b0, rup_pkg::CAP_PREVIOUS_TWO, "record two", EMPTY);
      // second application, left by the config reset pin
      put_update(C2);
      go = 1'b1;
      step();
      go = 1'b0;
      wait_load(mk_load(C2), rup_pkg::MS_APP);
      cfg_n = 1'b0;
      wait_load(ZERO_LOAD, rup_pkg::MS_FACTORY);
      cfg_n = 1'b1;
      fetch(1'b0, rup_pkg::CAP_PREVIOUS_ONE, "record one",
         64'({1'b0, 5'h10, rup_pkg::MS_APP, boot(C2)}));
      fetch(1'b0, rup_pkg::CAP_PREVIOUS_TWO, "record two",
         64'({1'b0, 5'h08, rup_pkg::MS_APP, boot(C1)}));
      $display("test error records done");
      // status pin from factory, then a reset in mid-run
      repeat (6) step();
      stat_n = 1'b0;
      wait_load(ZERO_LOAD, rup_pkg::MS_FACTORY);
      stat_n = 1'b1;
      repeat (20) step();
      do_reset();
      fetch(1'b0, rup_pkg::CAP_PREVIOUS_ONE, "record after reset", EMPTY);
      $display("test pins and reset done");
      end_of_test();
   end
endmodule // rup_status_reload_test
`default_nettype wire
